// >>> hdl/rtcsp_pkg.sv
// shared constants of the serial host port and alarm registers
package rtcsp_pkg;

    // ========================================================
    // register map (4-bit address pointer)
    localparam logic [3:0] WEEKLY_ALARM_MINUTE_ADDR = 4'h8;
    localparam logic [3:0] WEEKLY_ALARM_HOUR_ADDR = 4'h9;
    localparam logic [3:0] WEEKLY_ALARM_DAY_MASK_ADDR = 4'ha;
    localparam logic [3:0] DAILY_ALARM_MINUTE_ADDR = 4'hb;
    localparam logic [3:0] DAILY_ALARM_HOUR_ADDR = 4'hc;
    localparam int ALARM_REG_COUNT = 5;

    // ========================================================
    // writable bits of each alarm register, in address order
    localparam logic [7:0] MINUTE_FIELD_MASK = 8'h7f;
    localparam logic [7:0] HOUR_FIELD_MASK = 8'h3f;
    localparam logic [7:0] DAY_MASK_FIELD_MASK = 8'h7f;
    localparam logic [7:0] ALARM_FIELD_MASK [ALARM_REG_COUNT] = '{
        MINUTE_FIELD_MASK, HOUR_FIELD_MASK, DAY_MASK_FIELD_MASK,
        MINUTE_FIELD_MASK, HOUR_FIELD_MASK};
    // hour bit 5: pm flag in 12-hour mode, tens-high digit in 24-hour mode
    localparam int HOUR_PM_OR_TENS_HIGH_BIT = 5;
    localparam logic [2:0] LAST_WEEKDAY = 3'h6;

    // ========================================================
    // transfer format codes (low nibble of the command byte)
    localparam logic [3:0] FMT_SINGLE_WRITE = 4'h8;
    localparam logic [3:0] FMT_BURST_WRITE = 4'h0;
    localparam logic [3:0] FMT_SINGLE_READ = 4'hc;
    localparam logic [3:0] FMT_BURST_READ = 4'h4;
    localparam logic [2:0] LAST_BIT_INDEX = 3'h7;

    // ========================================================
    // timing
    localparam int unsigned CLK_FREQ_HZ = 25_000_000;
    localparam int unsigned CARRY_HOLD_TIME_MS = 1000;
    localparam int unsigned CARRY_HOLD_CYCLES = CLK_FREQ_HZ / 1000 * CARRY_HOLD_TIME_MS;

    typedef enum logic [4:0] {
        RTCSP_IDLE = 5'b00001,
        RTCSP_CMD = 5'b00010,
        RTCSP_WDATA = 5'b00100,
        RTCSP_RDATA = 5'b01000,
        RTCSP_SKIP = 5'b10000
    } rtcsp_state_type;

endpackage

// >>> hdl/rtcsp_serial_port.sv
// three-wire serial host port with weekly and daily alarm registers

// How it works
// - weekly hour bit5: pm flag or tens-high
// - daily hour bit5: pm flag or tens-high
// - 12-hour hours stored raw, compared raw
// - day bit per weekday 0..6 gates weekly
// - all day bits clear: weekly never matches
// - alarm contents undefined after power-up
// - sclk low at start: drive rise, sample fall
// - sclk high at start: drive fall, sample rise
// - session spans chip enable high; reset after
// - command: high nibble address, low nibble format
// - every byte shifted msb first
// - code 8h writes one data byte
// - after single transfer, next byte is command
// - code 0h burst write, pointer wraps f to 0
// - code ch single read, 4h burst read
// - hold seconds carry while enabled, max 1s
module rtcsp_serial_port #(
    parameter int unsigned HOLD_CYCLES = rtcsp_pkg::CARRY_HOLD_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic chip_enable_pin,
    input wire logic serial_clock_pin,
    input wire logic serial_data_io_pin_in,
    output logic serial_data_io_pin_out,
    output logic serial_data_io_pin_oe,
    input wire logic power_on_flag,
    input wire logic [6:0] current_minute,
    input wire logic [5:0] current_hour,
    input wire logic [2:0] weekday_counter,
    output logic weekly_alarm_match,
    output logic daily_alarm_match,
    output logic seconds_carry_hold
);
    // ========================================================
    // pin synchronisation and edge detection
    logic ce_s;
    logic sclk_s;
    logic din_s;
    logic ce_p_q;
    logic sclk_p_q;

    rtcsp_sync2 #(
        .WIDTH(3)
    ) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in({chip_enable_pin, serial_clock_pin, serial_data_io_pin_in}),
        .sync_out({ce_s, sclk_s, din_s})
    );

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ce_p_q <= 1'b0;
            sclk_p_q <= 1'b0;
        end else begin
            ce_p_q <= ce_s;
            sclk_p_q <= sclk_s;
        end
    end

    wire ce_rise = ce_s & ~ce_p_q;
    wire sclk_rise = sclk_s & ~sclk_p_q;
    wire sclk_fall = ~sclk_s & sclk_p_q;

    // ========================================================
    // serial engine
    rtcsp_pkg::rtcsp_state_type state_q;
    rtcsp_pkg::rtcsp_state_type state_d;
    logic pol_q;
    logic burst_q;
    logic [2:0] bit_cnt_q;
    logic [7:0] rx_q;
    logic [7:0] tx_q;
    logic [3:0] addr_q;
    logic [3:0] addr_d;

    // edge roles fixed per session by the sclk level at chip enable rise
    wire sample_edge = ce_s & (pol_q ? sclk_rise : sclk_fall);
    wire drive_edge = ce_s & (pol_q ? sclk_fall : sclk_rise);
    wire [7:0] rx_next = {rx_q[6:0], din_s};
    wire byte_done = sample_edge & (bit_cnt_q == rtcsp_pkg::LAST_BIT_INDEX);
    wire [3:0] fmt = rx_next[3:0];
    wire in_cmd = (state_q == rtcsp_pkg::RTCSP_CMD);
    wire in_wdata = (state_q == rtcsp_pkg::RTCSP_WDATA);
    wire in_rdata = (state_q == rtcsp_pkg::RTCSP_RDATA);
    wire fmt_write = (fmt == rtcsp_pkg::FMT_SINGLE_WRITE) | (fmt == rtcsp_pkg::FMT_BURST_WRITE);
    wire fmt_read = (fmt == rtcsp_pkg::FMT_SINGLE_READ) | (fmt == rtcsp_pkg::FMT_BURST_READ);
    wire fmt_burst = (fmt == rtcsp_pkg::FMT_BURST_WRITE) | (fmt == rtcsp_pkg::FMT_BURST_READ);
    wire data_done = byte_done & (in_wdata | in_rdata);
    wire wr_strobe = byte_done & in_wdata;

    always_comb begin
        state_d = state_q;
        case (state_q)
            rtcsp_pkg::RTCSP_IDLE: begin
                if (ce_rise) begin
                    state_d = rtcsp_pkg::RTCSP_CMD;
                end
            end
            rtcsp_pkg::RTCSP_CMD: begin
                if (byte_done) begin
                    if (fmt_write) begin
                        state_d = rtcsp_pkg::RTCSP_WDATA;
                    end else if (fmt_read) begin
                        state_d = rtcsp_pkg::RTCSP_RDATA;
                    end else begin
                        state_d = rtcsp_pkg::RTCSP_SKIP;
                    end
                end
            end
            rtcsp_pkg::RTCSP_WDATA, rtcsp_pkg::RTCSP_RDATA: begin
                if (byte_done && !burst_q) begin
                    state_d = rtcsp_pkg::RTCSP_CMD;
                end
            end
            rtcsp_pkg::RTCSP_SKIP: begin
                state_d = rtcsp_pkg::RTCSP_SKIP;
            end
            default: begin
                state_d = rtcsp_pkg::RTCSP_IDLE;
            end
        endcase
        if (!ce_s) begin
            state_d = rtcsp_pkg::RTCSP_IDLE;
        end
    end

    // pointer loads from the command, steps after each burst byte
    assign addr_d = (byte_done & in_cmd) ? rx_next[7:4] :
                    (data_done & burst_q) ? 4'(addr_q + 4'h1) : addr_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= rtcsp_pkg::RTCSP_IDLE;
            pol_q <= 1'b0;
            burst_q <= 1'b0;
            bit_cnt_q <= 3'h0;
            rx_q <= 8'h00;
            addr_q <= 4'h0;
        end else begin
            state_q <= state_d;
            addr_q <= addr_d;
            rx_q <= sample_edge ? rx_next : rx_q;
            if (ce_rise) begin
                pol_q <= sclk_s;
            end
            if (byte_done & in_cmd) begin
                burst_q <= fmt_burst;
            end
            if (!ce_s || ce_rise) begin
                bit_cnt_q <= 3'h0;
            end else if (sample_edge) begin
                bit_cnt_q <= 3'(bit_cnt_q + 3'h1);
            end
        end
    end

    // ========================================================
    // alarm registers, no reset: contents are undefined at power-up
    logic [7:0] alarm_q [rtcsp_pkg::ALARM_REG_COUNT];
    logic [7:0] rd_data;

    genvar gi;
    generate
        for (gi = 0; gi < rtcsp_pkg::ALARM_REG_COUNT; gi++) begin : g_alarm
            wire hit = wr_strobe & (addr_q == 4'(rtcsp_pkg::WEEKLY_ALARM_MINUTE_ADDR + gi));
            always_ff @(posedge clk) begin
                if (hit) begin
                    alarm_q[gi] <= rx_next & rtcsp_pkg::ALARM_FIELD_MASK[gi];
                end
            end
        end
    endgenerate

    wire [3:0] rd_addr = addr_d;
    wire rd_in_map = (rd_addr >= rtcsp_pkg::WEEKLY_ALARM_MINUTE_ADDR) &&
                     (rd_addr <= rtcsp_pkg::DAILY_ALARM_HOUR_ADDR);
    wire [2:0] rd_index = 3'(rd_addr - rtcsp_pkg::WEEKLY_ALARM_MINUTE_ADDR);
    // addresses outside this block read as zero
    assign rd_data = rd_in_map ? alarm_q[rd_index] : 8'h00;

    // ========================================================
    // serial output
    wire tx_load = byte_done & ((in_cmd & fmt_read) | (in_rdata & burst_q));

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_q <= 8'h00;
            serial_data_io_pin_out <= 1'b0;
            serial_data_io_pin_oe <= 1'b0;
        end else begin
            serial_data_io_pin_oe <= (state_d == rtcsp_pkg::RTCSP_RDATA);
            if (tx_load) begin
                tx_q <= rd_data;
            end else if (drive_edge & in_rdata) begin
                tx_q <= {tx_q[6:0], 1'b0};
            end
            if (drive_edge & in_rdata) begin
                serial_data_io_pin_out <= tx_q[7];
            end
        end
    end

    // ========================================================
    // alarm comparison and seconds carry hold
    wire [7:0] day_mask_ext = {1'b0, alarm_q[2][6:0]};
    wire week_enabled = |alarm_q[2][6:0];
    wire day_hit = (weekday_counter <= rtcsp_pkg::LAST_WEEKDAY) & day_mask_ext[weekday_counter];
    wire week_time_hit = (current_minute == alarm_q[0][6:0]) && (current_hour == alarm_q[1][5:0]);
    wire day_time_hit = (current_minute == alarm_q[3][6:0]) && (current_hour == alarm_q[4][5:0]);
    logic [31:0] hold_cnt_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            weekly_alarm_match <= 1'b0;
            daily_alarm_match <= 1'b0;
            seconds_carry_hold <= 1'b0;
            hold_cnt_q <= 32'h0;
        end else begin
            // undefined contents must not raise a match before software sets them
            weekly_alarm_match <= ~power_on_flag & week_enabled & day_hit & week_time_hit;
            daily_alarm_match <= ~power_on_flag & day_time_hit;
            if (!ce_s) begin
                hold_cnt_q <= 32'h0;
            end else if (hold_cnt_q < HOLD_CYCLES) begin
                hold_cnt_q <= hold_cnt_q + 32'h1;
            end
            seconds_carry_hold <= ce_s & (hold_cnt_q < HOLD_CYCLES);
        end
    end

    // ========================================================
    // checks
    a_ce_fall_idle: assert property (@(posedge clk) disable iff (sys_rst)
        (!ce_s) |=> (state_q == rtcsp_pkg::RTCSP_IDLE))
        else $error("session state not cleared after chip enable low");

    a_edge_polarity: assert property (@(posedge clk) disable iff (sys_rst)
        ce_rise |=> (pol_q == $past(sclk_s)))
        else $error("edge polarity not taken at chip enable rise");

    a_cmd_addr_load: assert property (@(posedge clk) disable iff (sys_rst)
        (byte_done && in_cmd && ce_s) |=> (addr_q == $past(rx_next[7:4])))
        else $error("address pointer not loaded from command");

    a_single_to_cmd: assert property (@(posedge clk) disable iff (sys_rst)
        (data_done && !burst_q && ce_s) |=> (state_q == rtcsp_pkg::RTCSP_CMD) ##1 !serial_data_io_pin_oe)
        else $error("single transfer did not return to command");

    a_burst_wrap: assert property (@(posedge clk) disable iff (sys_rst)
        (data_done && burst_q && addr_q == 4'hf) |=> (addr_q == 4'h0))
        else $error("burst pointer did not wrap");

    a_read_drive_msb: assert property (@(posedge clk) disable iff (sys_rst)
        (drive_edge && in_rdata) |=> (serial_data_io_pin_out == $past(tx_q[7])))
        else $error("read data not shifted msb first");

    a_read_oe_rise: assert property (@(posedge clk) disable iff (sys_rst)
        (byte_done && in_cmd && fmt_read && ce_s) |=> serial_data_io_pin_oe)
        else $error("data pin not driven after read command");

    a_oe_session: assert property (@(posedge clk) disable iff (sys_rst)
        (!ce_s) |=> !serial_data_io_pin_oe)
        else $error("data pin driven outside a session");

    a_burst_step: assert property (@(posedge clk) disable iff (sys_rst)
        (data_done && burst_q && ce_s) |=> (addr_q == 4'($past(addr_q) + 4'h1)))
        else $error("burst pointer did not step");

    a_write_lands: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_strobe && addr_q == rtcsp_pkg::DAILY_ALARM_MINUTE_ADDR) |=>
        (alarm_q[3] == ($past(rx_next) & rtcsp_pkg::MINUTE_FIELD_MASK)))
        else $error("single write did not land");

    a_upper_zero: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_strobe && addr_q == rtcsp_pkg::WEEKLY_ALARM_HOUR_ADDR) |=> (alarm_q[1][7:6] == 2'b00))
        else $error("unused hour bits stored");

    a_week_disable: assert property (@(posedge clk) disable iff (sys_rst)
        (!week_enabled || !day_hit) |=> !weekly_alarm_match)
        else $error("weekly alarm matched on a disabled day");

    a_daily_match: assert property (@(posedge clk) disable iff (sys_rst)
        (day_time_hit && !power_on_flag) |=> daily_alarm_match)
        else $error("daily alarm missed a match");

    a_hold_release: assert property (@(posedge clk) disable iff (sys_rst)
        (!ce_s) |=> !seconds_carry_hold ##1 (hold_cnt_q <= 32'h1))
        else $error("carry hold not released at chip enable low");

    a_hold_rise: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(ce_s) |=> seconds_carry_hold)
        else $error("carry hold not raised at session start");

    a_day7_never: assert property (@(posedge clk) disable iff (sys_rst)
        (weekday_counter == 3'h7) |=> !weekly_alarm_match)
        else $error("weekly alarm matched on weekday seven");
endmodule

// >>> hdl/rtcsp_sync2.sv
// two flip-flop synchroniser for pin inputs
module rtcsp_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// >>> sim/rtc_alarm_regs_serial_host_port_bench.sv
// self-checking bench of the serial host port and alarm registers
module rtc_alarm_regs_serial_host_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic pwr = 1'b1;
    logic [6:0] cur_min = 7'h00;
    logic [5:0] cur_hr = 6'h00;
    logic [2:0] wday = 3'h0;
    logic ce, sclk, hdrv, hoe, sio_wire, dout, doe, wmatch, dmatch, hold;
    logic last_q = 1'b0;
    logic [7:0] rx, v;
    logic [3:0] a;
    logic [7:0] val [5];
    int miscompares = 0;
    int checks = 0;
    always #20 clk = ~clk;
    // released line shows a toggling pattern, never a held value
    always @(posedge clk) last_q <= sio_wire;
    assign sio_wire = doe ? dout : (hoe ? hdrv : ~last_q);
    rtcsp_host_model host (.clk(clk), .ce(ce), .sclk(sclk), .sio_drv(hdrv), .sio_oe(hoe), .sio_wire(sio_wire));
    rtcsp_serial_port #(.HOLD_CYCLES(64)) dut (.clk(clk), .sys_rst(sys_rst), .chip_enable_pin(ce),
        .serial_clock_pin(sclk), .serial_data_io_pin_in(sio_wire), .serial_data_io_pin_out(dout),
        .serial_data_io_pin_oe(doe), .power_on_flag(pwr), .current_minute(cur_min), .current_hour(cur_hr),
        .weekday_counter(wday), .weekly_alarm_match(wmatch), .daily_alarm_match(dmatch),
        .seconds_carry_hold(hold));
    // ========================================
    function automatic logic [7:0] keep(input logic [3:0] ad, input logic [7:0] d);
        case (ad)
            rtcsp_pkg::WEEKLY_ALARM_MINUTE_ADDR, rtcsp_pkg::DAILY_ALARM_MINUTE_ADDR: return d & 8'h7f;
            rtcsp_pkg::WEEKLY_ALARM_HOUR_ADDR, rtcsp_pkg::DAILY_ALARM_HOUR_ADDR: return d & 8'h3f;
            rtcsp_pkg::WEEKLY_ALARM_DAY_MASK_ADDR: return d & 8'h7f;
            default: return 8'h00;
        endcase
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] ad, input logic [7:0] d);
        host.byte_io({ad, rtcsp_pkg::FMT_SINGLE_WRITE}, 1'b1, rx);
        host.byte_io(d, 1'b1, rx);
    endtask
    task automatic rd(input logic [3:0] ad, output logic [7:0] d);
        host.byte_io({ad, rtcsp_pkg::FMT_SINGLE_READ}, 1'b1, rx);
        host.byte_io(8'h00, 1'b0, d);
    endtask
    task automatic at_time(input logic [6:0] m, input logic [5:0] h, input logic [2:0] d, input logic p,
                           input logic ew, input logic ed);
        cur_min = m;
        cur_hr = h;
        wday = d;
        pwr = p;
        repeat (3) @(negedge clk);
        check({7'h00, wmatch}, {7'h00, ew});
        check({7'h00, dmatch}, {7'h00, ed});
    endtask
    // expected {weekly, daily} from the stored values held in val
    function automatic logic [1:0] alarm_expect(input logic [6:0] m, input logic [5:0] h, input logic [2:0] d,
                                                input logic p);
        logic wk;
        logic dy;
        wk = !p && (val[2][d] === 1'b1) && (m === val[0][6:0]) && (h === val[1][5:0]);
        dy = !p && (m === val[3][6:0]) && (h === val[4][5:0]);
        return {wk, dy};
    endfunction
    // random times, often steered onto a stored pair so matches occur
    task automatic rand_times(input int n);
        logic [7:0] r;
        logic [6:0] m;
        logic [5:0] h;
        logic [2:0] d;
        logic p;
        logic [1:0] e;
        for (int k = 0; k < n; k++) begin
            r = 8'($urandom);
            m = r[0] ? (r[1] ? val[0][6:0] : val[3][6:0]) : 7'($urandom);
            h = r[0] ? (r[1] ? val[1][5:0] : val[4][5:0]) : 6'($urandom);
            d = r[6] ? 3'h5 : 3'($urandom);
            p = r[4] & r[5];
            e = alarm_expect(m, h, d, p);
            at_time(m, h, d, p, e[1], e[0]);
        end
    endtask
    initial begin
        #1ms;
        miscompares++;
        summarize();
    end
    // ========================================
    initial begin
        rx = 8'($urandom(44));
        repeat (8) @(negedge clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk);
        // power-up flag still set: unknown alarm contents stay masked
        check({6'h00, wmatch, dmatch}, 8'h00);
        // chained single write then read, both sample modes
        for (int m = 0; m < 2; m++) begin
            host.start(m[0]);
            check({7'h00, hold}, 8'h01);
            for (int i = 0; i < 5; i++) begin
                a = 4'(8 + i);
                v = 8'($urandom);
                val[i] = keep(a, v);
                wr(a, v);
                check({7'h00, hold}, 8'h00);
                rd(a, rx);
                check(rx, val[i]);
            end
            host.stop();
            check({7'h00, hold}, 8'h00);
        end
        // burst write from f wraps through 0 into the alarm block
        host.start(1'b0);
        host.byte_io({4'hf, rtcsp_pkg::FMT_BURST_WRITE}, 1'b1, rx);
        for (int i = 0; i < 14; i++) begin
            a = 4'(i + 15);
            v = 8'($urandom);
            host.byte_io(v, 1'b1, rx);
            if (i >= 9) val[i - 9] = keep(a, v);
        end
        host.stop();
        host.start(1'b1);
        host.byte_io({4'h7, rtcsp_pkg::FMT_BURST_READ}, 1'b1, rx);
        for (int i = 0; i < 6; i++) begin
            host.byte_io(8'h00, 1'b0, rx);
            if (i == 0) check(rx, 8'h00);
            else check(rx, val[i - 1]);
        end
        host.stop();
        // unknown format leaves registers alone
        host.start(1'b0);
        host.byte_io({rtcsp_pkg::WEEKLY_ALARM_MINUTE_ADDR, 4'h2}, 1'b1, rx);
        host.byte_io(~val[0], 1'b1, rx);
        host.stop();
        host.start(1'b0);
        rd(rtcsp_pkg::WEEKLY_ALARM_MINUTE_ADDR, rx);
        check(rx, val[0]);
        // existing times only: noon pm weekly on days 1 and 5, midnight 59 daily
        wr(4'h8, 8'h30);
        wr(4'h9, 8'h32);
        wr(4'ha, 8'h22);
        wr(4'hb, 8'h59);
        wr(4'hc, 8'h12);
        host.stop();
        val = '{8'h30, 8'h32, 8'h22, 8'h59, 8'h12};
        at_time(7'h30, 6'h32, 3'h1, 1'b0, 1'b1, 1'b0);
        at_time(7'h30, 6'h32, 3'h5, 1'b0, 1'b1, 1'b0);
        at_time(7'h30, 6'h32, 3'h2, 1'b0, 1'b0, 1'b0);
        at_time(7'h30, 6'h12, 3'h1, 1'b0, 1'b0, 1'b0);
        at_time(7'h59, 6'h12, 3'h3, 1'b0, 1'b0, 1'b1);
        at_time(7'h59, 6'h32, 3'h3, 1'b0, 1'b0, 1'b0);
        at_time(7'h59, 6'h12, 3'h3, 1'b1, 1'b0, 1'b0);
        at_time(7'h30, 6'h32, 3'h1, 1'b1, 1'b0, 1'b0);
        rand_times(32);
        host.start(1'b1);
        wr(4'ha, 8'h80);
        host.stop();
        val[2] = 8'h00;
        for (int d = 0; d < 8; d++) begin
            at_time(7'h30, 6'h32, 3'(d), 1'b0, 1'b0, 1'b0);
        end
        rand_times(16);
        // reset in mid-run: every output drops, the link recovers
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        check({3'h0, hold, wmatch, dmatch, doe, dout}, 8'h00);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk);
        host.start(1'b0);
        v = 8'($urandom);
        wr(rtcsp_pkg::DAILY_ALARM_HOUR_ADDR, v);
        rd(rtcsp_pkg::DAILY_ALARM_HOUR_ADDR, rx);
        check(rx, keep(rtcsp_pkg::DAILY_ALARM_HOUR_ADDR, v));
        host.stop();
        summarize();
    end
endmodule

// >>> sim/rtcsp_host_model.sv
// host cpu model driving the three-wire serial link
module rtcsp_host_model (
    input wire logic clk,
    output logic ce,
    output logic sclk,
    output logic sio_drv,
    output logic sio_oe,
    input wire logic sio_wire
);
    timeunit 1ns;
    timeprecision 1ps;
    logic idle_lvl;
    initial begin
        ce = 1'b0;
        sclk = 1'b0;
        sio_drv = 1'b0;
        sio_oe = 1'b0;
        idle_lvl = 1'b0;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // ========================================
    // framing; sclk settles before ce rises so the mode is unambiguous
    task automatic start(input logic lvl);
        sclk = lvl;
        idle_lvl = lvl;
        cyc(2);
        ce = 1'b1;
        cyc(6);
    endtask
    task automatic stop();
        cyc(4);
        ce = 1'b0;
        sio_oe = 1'b0;
        cyc(6);
    endtask
    // ========================================
    // one whole byte, msb first; read sampled late in the cell for margin
    task automatic byte_io(input logic [7:0] tx, input logic drive, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sclk = ~idle_lvl;
            sio_oe = drive;
            sio_drv = tx[i];
            cyc(4);
            sclk = idle_lvl;
            cyc(2);
            rx[i] = sio_wire;
            sio_oe = 1'b0;
            cyc(2);
        end
    endtask
endmodule
